// ---- rtl/timer16_cc_pkg.sv ----
// constants for the 16-bit timer capture/compare block
// assumes a 16-bit register port with separate write and read strobes
package timer16_cc_pkg;
  // register addresses
  localparam logic [15:0] addr_timer_mode_ctrl   = 16'hff60;
  localparam logic [15:0] addr_prescale_edge_cfg = 16'hff61;
  localparam logic [15:0] addr_cap_cmp_ctrl      = 16'hff62;
  localparam logic [15:0] addr_count_reg         = 16'hff10;
  localparam logic [15:0] addr_cap_cmp_a         = 16'hff12;
  localparam logic [15:0] addr_cap_cmp_b         = 16'hff14;
  // reset values
  localparam logic [7:0]  rst_byte               = 8'h00;
  localparam logic [15:0] rst_word               = 16'h0000;
  // field positions, timer_mode_ctrl
  localparam int          pos_overflow_flag      = 0;
  localparam int          pos_out_toggle_sel     = 1;
  localparam int          pos_op_mode_lo         = 2;
  localparam int          pos_op_mode_hi         = 3;
  // field positions, prescale_edge_cfg
  localparam int          pos_clk_sel_lo         = 0;
  localparam int          pos_clk_sel_hi         = 1;
  localparam int          pos_edge_a_sel_lo      = 4;
  localparam int          pos_edge_a_sel_hi      = 5;
  localparam int          pos_edge_b_sel_lo      = 6;
  localparam int          pos_edge_b_sel_hi      = 7;
  // field positions, cap_cmp_ctrl
  localparam int          pos_a_capture_mode     = 0;
  localparam int          pos_a_trigger_src      = 1;
  localparam int          pos_b_capture_mode     = 2;
  // operating modes
  localparam logic [1:0]  mode_stop              = 2'h0;
  localparam logic [1:0]  mode_free_run          = 2'h1;
  localparam logic [1:0]  mode_clear_on_a        = 2'h2;
  localparam logic [1:0]  mode_clear_on_match    = 2'h3;
  // valid edge codes
  localparam logic [1:0]  edge_falling           = 2'h0;
  localparam logic [1:0]  edge_rising            = 2'h1;
  localparam logic [1:0]  edge_both              = 2'h3;
  // counter limits
  localparam logic [15:0] count_max              = 16'hffff;
  localparam logic [15:0] count_zero             = 16'h0000;
  localparam logic [15:0] count_one              = 16'h0001;
  // default count clock divider
  localparam int          count_div_default      = 2;
endpackage

// ---- rtl/timer16_capture_compare.sv ----
// 16-bit timer counter with two capture/compare registers and mode control
// assumes a single system clock, software access over a plain strobe port,
// and external pulse inputs that are asynchronous to the clock
//
// Notes on behaviour
// - input A trigger for register A captures on the opposite edge; both gives none.
// - input B trigger for register A captures on input B's selected edge.
// - edge fields sit at bits 5:4 and 7:6; A source/mode at 1:0.
// - register A zero raises its match only on zero-to-one after a wrap.
// - a compare below the count lets the counter run through overflow.
// - compare-mode registers ignore capture triggers.
// - capture beats a coinciding write; stop with trigger gives no capture.
// - bit 2 of the control register picks register B's function.
// - reset clears register B.
// - compare-mode register B raises its interrupt on equality with the counter.
// - capture-mode register B captures on input A's selected edge.
// - register B zero raises its match only on zero-to-one after a wrap.
// - register contents after stop need not be kept.
// - reset clears the mode control register: stop, no overflow.
// - nonzero upper mode bits run the counter; zero stops it.
// - modes: stop-clear, free-run, clear on input A edge, clear on A match.
// - output toggles on matches, also on input A edge when selected.
// - interrupts from matches or capture edges, none in stop mode.
// - overflow sets bit 0 of the mode control register.
// - clearing overflow before the counter reaches one has no effect.
// - register B mode bit: zero compare, one capture.
`timescale 1ns/1ns
module timer16_capture_compare #(
  parameter int count_div = timer16_cc_pkg::count_div_default
) (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        ext_in_a,
  input  wire logic        ext_in_b,
  output logic             timer_out,
  output logic             match_a_irq,
  output logic             match_b_irq
);
  import timer16_cc_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [15:0] count_reg;
  logic [15:0] cap_cmp_a;
  logic [15:0] cap_cmp_b;
  logic [1:0]  op_mode;
  logic        out_toggle_sel;
  logic        overflow_flag;
  logic [1:0]  clk_sel;
  logic [1:0]  edge_a_cfg;
  logic [1:0]  edge_b_cfg;
  logic        a_capture_mode;
  logic        a_trigger_src;
  logic        b_capture_mode;
  logic        wrap_pending;
  logic [7:0]  div_cnt;
  logic        count_en;
  logic        a_s1, a_s2, a_s3;
  logic        b_s1, b_s2, b_s3;

  ////////////////////////////////////////////////////////////////////////
  // decode and event terms
  logic        wr_tmc, wr_prm, wr_crc, wr_a, wr_b;
  logic        rise_a, fall_a, rise_b, fall_b;
  logic        valid_a, valid_b, opp_a;
  logic        running;
  logic        trig_a, trig_b;
  logic        match_a, match_b;
  logic        clear_now;
  logic        ovf_set;

  // valid edge of an input for a given edge code; code one-zero never hits
  function automatic logic edge_hit(input logic [1:0] code, input logic rise,
                                    input logic fall);
    logic hit;
    hit = 1'b0;
    case (code)
      edge_falling: hit = fall;
      edge_rising:  hit = rise;
      edge_both:    hit = rise | fall;
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction

  // register strobes
  assign wr_tmc = reg_wr && (reg_addr == addr_timer_mode_ctrl);
  assign wr_prm = reg_wr && (reg_addr == addr_prescale_edge_cfg);
  assign wr_crc = reg_wr && (reg_addr == addr_cap_cmp_ctrl);
  assign wr_a   = reg_wr && (reg_addr == addr_cap_cmp_a);
  assign wr_b   = reg_wr && (reg_addr == addr_cap_cmp_b);

  // edges seen on the synchronised inputs
  assign rise_a  = a_s2 & ~a_s3;
  assign fall_a  = ~a_s2 & a_s3;
  assign rise_b  = b_s2 & ~b_s3;
  assign fall_b  = ~b_s2 & b_s3;
  assign valid_a = edge_hit(edge_a_cfg, rise_a, fall_a);
  assign valid_b = edge_hit(edge_b_cfg, rise_b, fall_b);

  // opposite-phase edge of input A, nothing when both edges are valid
  always_comb begin
    opp_a = 1'b0;
    case (edge_a_cfg)
      edge_rising:  opp_a = fall_a;
      edge_falling: opp_a = rise_a;
      default:      opp_a = 1'b0;
    endcase
  end

  // counter runs in every mode but stop
  assign running = (op_mode != mode_stop);

  // accepted capture triggers, only in capture mode and while running
  assign trig_a = running && a_capture_mode &&
                  (a_trigger_src ? opp_a : valid_b);
  assign trig_b = running && b_capture_mode && valid_a;

  // compare matches, zero value only counts right after a wrap
  assign match_a = running && !a_capture_mode && count_en &&
                   (count_reg == cap_cmp_a) &&
                   ((cap_cmp_a != count_zero) || wrap_pending);
  assign match_b = running && !b_capture_mode && count_en &&
                   (count_reg == cap_cmp_b) &&
                   ((cap_cmp_b != count_zero) || wrap_pending);

  // clear-and-start conditions
  assign clear_now = ((op_mode == mode_clear_on_a) && valid_a) ||
                     ((op_mode == mode_clear_on_match) && match_a);

  // overflow when the counter steps past its maximum
  assign ovf_set = running && count_en && !clear_now && (count_reg == count_max);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers and edge history
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      a_s1 <= 1'b0;
      a_s2 <= 1'b0;
      a_s3 <= 1'b0;
      b_s1 <= 1'b0;
      b_s2 <= 1'b0;
      b_s3 <= 1'b0;
    end else begin
      a_s1 <= ext_in_a;
      a_s2 <= a_s1;
      a_s3 <= a_s2;
      b_s1 <= ext_in_b;
      b_s2 <= b_s1;
      b_s3 <= b_s2;
    end
  end

  // count clock enable divider
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_cnt  <= 8'h00;
      count_en <= 1'b0;
    end else if (div_cnt == 8'(count_div - 1)) begin
      div_cnt  <= 8'h00;
      count_en <= 1'b1;
    end else begin
      div_cnt  <= div_cnt + 8'h01;
      count_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_reg <= rst_word;
    end else if (!running) begin
      count_reg <= count_zero;
    end else if (clear_now) begin
      count_reg <= count_zero;
    end else if (count_en) begin
      count_reg <= count_reg + count_one;
    end
  end

  // marks the span from the wrap to zero until the step to one
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrap_pending <= 1'b0;
    end else if (!running || clear_now) begin
      wrap_pending <= 1'b0;
    end else if (ovf_set) begin
      wrap_pending <= 1'b1;
    end else if (count_en && (count_reg == count_zero)) begin
      wrap_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode control register; a new overflow wins over a clear
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      op_mode        <= mode_stop;
      out_toggle_sel <= 1'b0;
      overflow_flag  <= 1'b0;
    end else begin
      if (wr_tmc) begin
        op_mode        <= {reg_wdata[pos_op_mode_hi], reg_wdata[pos_op_mode_lo]};
        out_toggle_sel <= reg_wdata[pos_out_toggle_sel];
      end
      if (ovf_set) begin
        overflow_flag <= 1'b1;
      end else if (wr_tmc) begin
        overflow_flag <= reg_wdata[pos_overflow_flag] | wrap_pending;
      end
    end
  end

  // edge and count clock configuration
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      clk_sel    <= 2'h0;
      edge_a_cfg <= edge_falling;
      edge_b_cfg <= edge_falling;
    end else if (wr_prm) begin
      clk_sel    <= {reg_wdata[pos_clk_sel_hi], reg_wdata[pos_clk_sel_lo]};
      edge_a_cfg <= {reg_wdata[pos_edge_a_sel_hi], reg_wdata[pos_edge_a_sel_lo]};
      edge_b_cfg <= {reg_wdata[pos_edge_b_sel_hi], reg_wdata[pos_edge_b_sel_lo]};
    end
  end

  // capture/compare control
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      a_capture_mode <= 1'b0;
      a_trigger_src  <= 1'b0;
      b_capture_mode <= 1'b0;
    end else if (wr_crc) begin
      a_capture_mode <= reg_wdata[pos_a_capture_mode];
      a_trigger_src  <= reg_wdata[pos_a_trigger_src];
      b_capture_mode <= reg_wdata[pos_b_capture_mode];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture/compare register A; capture wins over a write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cap_cmp_a <= rst_word;
    end else if (trig_a) begin
      cap_cmp_a <= count_reg;
    end else if (wr_a) begin
      cap_cmp_a <= reg_wdata;
    end
  end

  // capture/compare register B; capture wins over a write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cap_cmp_b <= rst_word;
    end else if (trig_b) begin
      cap_cmp_b <= count_reg;
    end else if (wr_b) begin
      cap_cmp_b <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt pulses, gated off in stop mode by the running terms
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      match_a_irq <= 1'b0;
      match_b_irq <= 1'b0;
    end else begin
      match_a_irq <= match_a | trig_a;
      match_b_irq <= match_b | trig_b;
    end
  end

  // timer output toggle, frozen in stop mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_out <= 1'b0;
    end else if (running && (match_a || match_b || (out_toggle_sel && valid_a))) begin
      timer_out <= ~timer_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, registered; unmapped addresses read zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= rst_word;
    end else if (reg_rd) begin
      case (reg_addr)
        addr_timer_mode_ctrl:
          reg_rdata <= {12'h000, op_mode, out_toggle_sel, overflow_flag};
        addr_prescale_edge_cfg:
          reg_rdata <= {8'h00, edge_b_cfg, edge_a_cfg, 2'h0, clk_sel};
        addr_cap_cmp_ctrl:
          reg_rdata <= {13'h0000, b_capture_mode, a_trigger_src, a_capture_mode};
        addr_count_reg: reg_rdata <= count_reg;
        addr_cap_cmp_a: reg_rdata <= cap_cmp_a;
        addr_cap_cmp_b: reg_rdata <= cap_cmp_b;
        default:        reg_rdata <= rst_word;
      endcase
    end
  end

endmodule

// ---- verification/ext_pulse_model.sv ----
// partner: pulse source driving the two timer input pins
// assumes the bench sets wanted levels; pins move one edge later
`timescale 1ns/1ns
module ext_pulse_model (
  input  wire logic clock,
  input  wire logic want_a,
  input  wire logic want_b,
  output logic      ext_in_a = 1'b0,
  output logic      ext_in_b = 1'b0
);
  // pins follow requests; the shared pin is only an input here
  always @(posedge clock) begin
    ext_in_a <= want_a;
    ext_in_b <= want_b;
  end
endmodule

// ---- verification/timer16_cc_properties.sv ----
// checker for the timer capture/compare block, top ports only
// assumes single clock domain and async active-low reset
`timescale 1ns/1ns
module timer16_cc_properties import timer16_cc_pkg::*; #(
  parameter int count_div = count_div_default
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [15:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        ext_in_a,
  input wire logic        ext_in_b,
  input wire logic        timer_out,
  input wire logic        match_a_irq,
  input wire logic        match_b_irq
);
  logic [1:0] mode_q;
  logic       tsel_q;
  logic       tsel_d;
  logic [3:0] stop_age;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////
  // shadow of mode and toggle select from register writes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_q <= mode_stop;
      tsel_q <= 1'b0;
      tsel_d <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == addr_timer_mode_ctrl) begin
        mode_q <= reg_wdata[3:2];
        tsel_q <= reg_wdata[1];
      end
      tsel_d <= tsel_q;
    end
  end
  // cycles spent in stop mode, saturating
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) stop_age <= 4'h0;
    else if (mode_q != mode_stop) stop_age <= 4'h0;
    else if (stop_age != 4'hf) stop_age <= stop_age + 4'h1;
  end
  ////////////////////////////////////////////////////////////////
  stop_quiet_a: assert property (stop_age >= 4'h3 |-> !match_a_irq && !match_b_irq
    && $stable(timer_out)) else $error("activity while stopped");
  stop_clear_a: assert property (reg_rd && reg_addr == addr_count_reg && stop_age >= 4'h2
    |=> reg_rdata == count_zero) else $error("count not cleared in stop");
  toggle_cause_a: assert property (!tsel_q && !tsel_d && $changed(timer_out)
    |-> match_a_irq || match_b_irq) else $error("toggle without match");
  mode_back_a: assert property (reg_wr && reg_addr == addr_timer_mode_ctrl ##2 reg_rd
    && reg_addr == addr_timer_mode_ctrl |=> reg_rdata[3:1] == $past(reg_wdata[3:1], 3))
    else $error("mode readback wrong");
  edge_back_a: assert property (reg_wr && reg_addr == addr_prescale_edge_cfg ##2 reg_rd
    && reg_addr == addr_prescale_edge_cfg |=> reg_rdata[7:4] == $past(reg_wdata[7:4], 3))
    else $error("edge readback wrong");
  ctrl_back_a: assert property (reg_wr && reg_addr == addr_cap_cmp_ctrl ##2 reg_rd
    && reg_addr == addr_cap_cmp_ctrl |=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3))
    else $error("ctrl readback wrong");
  irq_b_pulse_a: assert property (match_b_irq |=> !match_b_irq)
    else $error("irq b longer than one cycle");
  irq_a_pulse_a: assert property (match_a_irq |=> !match_a_irq)
    else $error("irq a longer than one cycle");
  cover property (match_b_irq && $changed(timer_out));
  cover property (match_a_irq);
  cover property (reg_rd && reg_addr == addr_count_reg);
endmodule
bind timer16_capture_compare timer16_cc_properties #(.count_div(count_div)) props_i (
  .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_in_a(ext_in_a), .ext_in_b(ext_in_b),
  .timer_out(timer_out), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));

// ---- verification/tb_top.sv ----
// self-checking bench for the timer capture/compare block
// assumes count_div of 1 so the counter steps every clock
`timescale 1ns/1ns
module tb_top;
  import timer16_cc_pkg::*;
  logic        clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, want_a = 0, want_b = 0, o;
  logic [15:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d, c;
  logic        ext_in_a, ext_in_b, timer_out, match_a_irq, match_b_irq;
  int          mismatches = 0, checks_done = 0, na = 0, nb = 0, sa, sb, v, t, n;
  logic [15:0] al[6] = '{addr_timer_mode_ctrl, addr_prescale_edge_cfg, addr_cap_cmp_ctrl,
                         addr_cap_cmp_a, addr_cap_cmp_b, 16'h0000};
  logic [15:0] ctl[4] = '{16'h0003, 16'h0001, 16'h0004, 16'h0000};
  timer16_capture_compare #(.count_div(1)) timer16_capture_compare_i (.clock(clock),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_in_a(ext_in_a), .ext_in_b(ext_in_b),
    .timer_out(timer_out), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
  ext_pulse_model ext_pulse_model_i (.clock(clock), .want_a(want_a), .want_b(want_b),
    .ext_in_a(ext_in_a), .ext_in_b(ext_in_b));
  initial forever #5 clock = ~clock;
  // interrupt pulse counters
  always @(posedge clock) begin
    #1;
    if (match_a_irq === 1'b1) na++;
    if (match_b_irq === 1'b1) nb++;
  end
  ////////////////////////////////////////////////////////////////
  task summarize;
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] wd);
    @(posedge clock); #1 reg_addr = a; reg_wdata = wd; reg_wr = 1;
    @(posedge clock); #1 reg_wr = 0;
  endtask
  task rd(input logic [15:0] a, output logic [15:0] rv);
    @(posedge clock); #1 reg_addr = a; reg_rd = 1;
    @(posedge clock); #1 reg_rd = 0; rv = reg_rdata;
  endtask
  // waits for the chosen irq, counting cycles; gives up after a bound
  task wait_irq(input bit b, output int cyc);
    cyc = 0;
    do begin
      @(posedge clock); #1 cyc++;
    end while ((b ? match_b_irq : match_a_irq) !== 1'b1 && cyc < 200);
    chk("irq wait", 16'h0001, 16'((b ? match_b_irq : match_a_irq) === 1'b1));
    if (cyc >= 200) summarize;
  endtask
  function automatic int exp_irq(int k, int e, int r);
    if (k == 3) return 0;
    if (k == 0) return int'((e == 0 && r == 1) || (e == 1 && r == 0));
    return int'(e == 3 || (e == 1) == (r == 1));
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    v = $urandom(32'ha342);
    repeat (4) @(posedge clock);
    #1 resetn = 1;
    foreach (al[i]) begin
      rd(al[i], d);
      chk("reset value", rst_word, d);
    end
    wr(addr_count_reg, 16'h1234);
    rd(addr_count_reg, d);
    chk("count write", count_zero, d);
    repeat (4) begin
      t = $urandom_range(2, 0);
      t = (t == 2) ? 3 : t;
      v = $urandom_range(7, 0);
      wr(addr_prescale_edge_cfg, 16'(t * 80));
      rd(addr_prescale_edge_cfg, d);
      chk("edge cfg", 16'(t * 5), 16'(d[7:4]));
      wr(addr_cap_cmp_ctrl, 16'(v));
      rd(addr_cap_cmp_ctrl, d);
      chk("ctrl", 16'(v), 16'(d[2:0]));
      wr(addr_timer_mode_ctrl, 16'(v * 2));
      rd(addr_timer_mode_ctrl, d);
      chk("mode", 16'(v), 16'(d[3:1]));
    end
    wr(addr_timer_mode_ctrl, 16'h0000);
    wr(addr_cap_cmp_ctrl, 16'h0000);
    v = $urandom_range(40, 5);
    wr(addr_cap_cmp_b, 16'(v));
    o = timer_out;
    wr(addr_timer_mode_ctrl, 16'h0004);
    wait_irq(1, t);
    chk("toggle", {15'h0000, ~o}, 16'(timer_out));
    rd(addr_count_reg, d);
    chk("count at match", 16'(v + 2), d);
    wr(addr_timer_mode_ctrl, 16'h0000);
    v = $urandom_range(20, 3);
    wr(addr_cap_cmp_a, 16'(v));
    wr(addr_timer_mode_ctrl, 16'h000c);
    wait_irq(0, t);
    wait_irq(0, t);
    chk("match period", 16'(v + 1), 16'(t));
    // clear on input A rising edge, with the edge also toggling the output
    wr(addr_timer_mode_ctrl, 16'h0000);
    wr(addr_cap_cmp_a, 16'h8000);
    wr(addr_cap_cmp_b, 16'h8000);
    wr(addr_prescale_edge_cfg, 16'h0010);
    wr(addr_timer_mode_ctrl, 16'h000a);
    repeat ($urandom_range(30, 5)) @(posedge clock);
    #1 o = timer_out;
    want_a = 1'b1;
    repeat (8) @(posedge clock);
    #1 chk("edge toggle", {15'h0000, ~o}, 16'(timer_out));
    rd(addr_count_reg, d);
    chk("clear on edge", 16'h0005, d);
    want_a = 1'b0;
    for (int k = 0; k < 4; k++) for (int j = 0; j < 3; j++) begin
      t = (j == 2) ? 3 : j;
      wr(addr_timer_mode_ctrl, 16'h0000);
      wr(addr_cap_cmp_a, 16'h0000);
      wr(addr_cap_cmp_b, 16'h0000);
      wr(addr_cap_cmp_ctrl, ctl[k]);
      wr(addr_prescale_edge_cfg, 16'(t * 80));
      wr(addr_timer_mode_ctrl, 16'h0004);
      for (int r = 1; r >= 0; r--) begin
        sa = na;
        sb = nb;
        @(posedge clock); #1 if (k == 1) want_b = r[0]; else want_a = r[0];
        repeat (8) @(posedge clock);
        #1 n = (k == 2) ? nb - sb : (k == 3) ? na - sa + nb - sb : na - sa;
        chk("capture irqs", 16'(exp_irq(k, t, r)), 16'(n));
        if (r == 1 && k < 3 && exp_irq(k, t, r) == 1) begin
          rd((k == 2) ? addr_cap_cmp_b : addr_cap_cmp_a, d);
          rd(addr_count_reg, c);
          chk("captured count", 16'h0001, 16'(d != 0 && d < c));
        end
      end
    end
    wr(addr_timer_mode_ctrl, 16'h0000);
    wr(addr_cap_cmp_ctrl, 16'h0000);
    sa = na;
    sb = nb;
    wr(addr_timer_mode_ctrl, 16'h0004);
    // land a flag clear on the one cycle where the count sits at zero after the wrap
    repeat (65535) @(posedge clock);
    wr(addr_timer_mode_ctrl, 16'h0004);
    rd(addr_timer_mode_ctrl, d);
    chk("overflow flag", 16'h0001, 16'(d[0]));
    if (d[0] !== 1'b1) summarize;
    repeat (4) @(posedge clock);
    #1 chk("zero compare irqs", 16'h0002, 16'(na - sa + nb - sb));
    wr(addr_timer_mode_ctrl, 16'h0004);
    rd(addr_timer_mode_ctrl, d);
    chk("flag clear", 16'h0000, 16'(d[0]));
    summarize;
  end
endmodule
